/* core/bus_sense.sv */
// synchroniser, deglitch filter and start/stop detection for the bus pins
`timescale 1ns/1ps
module bus_sense
    import twi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic asel_i,
    bus_sense_if.src bus
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [2:0] filt_reg;
    logic [2:0] prev_reg;
    logic [1:0] hold_reg [3];

    // two-stage synchroniser; idle lines are high
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 3'h7;
            sync_reg <= 3'h7;
        end else begin
            meta_reg <= {asel_i, sda_i, scl_i};
            sync_reg <= meta_reg; // RL25
        end
    end

    // a new level must persist past the glitch window to be accepted
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            filt_reg <= 3'h7;
            prev_reg <= 3'h7;
            for (int i = 0; i < 3; i++) begin
                hold_reg[i] <= 2'h0;
            end
        end else begin
            prev_reg <= filt_reg;
            for (int i = 0; i < 3; i++) begin
                if (sync_reg[i] == filt_reg[i]) begin
                    hold_reg[i] <= 2'h0;
                end else if (hold_reg[i] == GLITCH_CNT) begin
                    filt_reg[i] <= sync_reg[i]; // RL25
                    hold_reg[i] <= 2'h0;
                end else begin
                    hold_reg[i] <= hold_reg[i] + 2'h1;
                end
            end
        end
    end

    // sda moving while scl stays high is a condition, never data
    assign bus.scl = filt_reg[0];
    assign bus.sda = filt_reg[1];
    assign bus.asel = filt_reg[2];
    assign bus.scl_rise = filt_reg[0] & ~prev_reg[0];
    assign bus.scl_fall = ~filt_reg[0] & prev_reg[0];
    assign bus.start = filt_reg[0] & prev_reg[0] & prev_reg[1] & ~filt_reg[1]; // RL3 RL4
    assign bus.stop = filt_reg[0] & prev_reg[0] & ~prev_reg[1] & filt_reg[1]; // RL4
endmodule

/* core/bus_sense_if.sv */
// filtered bus levels and condition strobes
`timescale 1ns/1ps
interface bus_sense_if;
    logic scl;
    logic sda;
    logic asel;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport src (output scl, sda, asel, scl_rise, scl_fall, start, stop);
    modport dst (input scl, sda, asel, scl_rise, scl_fall, start, stop);
endinterface

/* core/twi_pkg.sv */
// constants and types for the two-wire slave command port
// Rules from the document
// RL1: device is slave only; it never drives SCL; master clocks up to 400kHz.
// RL2: every word is eight bits followed by a ninth acknowledge bit.
// RL3: SDA changes only while SCL is low; changes while high are conditions.
// RL4: START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// RL5: a STOP anywhere aborts the transfer; START and STOP need separate pulses.
// RL6: repeated START restarts address reception, keeping transaction state.
// RL7: received address or data bytes are acknowledged by holding SDA low.
// RL8: when sending, release SDA in ninth clock and sample master acknowledge.
// RL9: NACK byte after address during reboot, EEPROM write, or illegal address.
// RL10: four-state select pin decodes to address bits 1010 00/01/10/11, X, R/W.
// RL11: send byte loads a valid address into pointer; disallowed codes get NACK.
// RL12: command bytes 94h and 95h are always acknowledged; here they are NACKed while busy.
// RL13: STOP before send-byte acknowledge leaves the pointer unchanged.
// RL14: receive byte returns byte at pointer, then pointer advances by one.
// RL15: write byte stores data only at a valid address; invalid gets NACK.
// RL16: read byte: invalid address is NACKed and pointer left unmodified.
// RL17: single reads and writes target the currently selected page.
// RL18: command 96h reboots, copying EEPROM 0Fh..7Dh into default page.
// RL19: command 97h triggers a fault store to EEPROM.
// RL20: 98h selects the extended page, 99h returns to default page.
// RL21: after 9Ah all addresses are EEPROM until 9Bh restores default.
// RL22: master watches acknowledges and retries failed transfers later.
// RL23: block write sends a count of one to sixteen then that many bytes.
// RL24: block read returns count sixteen first, then data until NACK or STOP.
// RL25: SCL and SDA are synchronised and deglitched before any detection.
// RL26: non-matching address: ignore traffic until START or STOP; stay off SDA.
package twi_pkg;
    localparam int CLK_NS = 100;
    localparam int GLITCH_NS = 100;
    localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] GLITCH_CNT = 2'(GLITCH_CYC);
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam logic [3:0] DEV_ID = 4'ha;
    localparam logic [7:0] CMD_BLK_WR = 8'h94;
    localparam logic [7:0] CMD_BLK_RD = 8'h95;
    localparam logic [7:0] CMD_REBOOT = 8'h96;
    localparam logic [7:0] CMD_FAULT = 8'h97;
    localparam logic [7:0] CMD_EXT_ON = 8'h98;
    localparam logic [7:0] CMD_EXT_OFF = 8'h99;
    localparam logic [7:0] CMD_EE_ON = 8'h9a;
    localparam logic [7:0] CMD_EE_OFF = 8'h9b;
    localparam logic [7:0] DEF_LAST = 8'h7d;
    localparam logic [7:0] EXT_LAST = 8'h3f;
    localparam logic [7:0] EE_LAST = 8'hff;
    localparam logic [7:0] BLK_BYTES = 8'h10;
    localparam logic [7:0] BOOT_FIRST = 8'h0f;
    localparam logic [7:0] BOOT_LAST = 8'h7d;
    localparam logic [7:0] PTR_RESET = 8'h00;
    typedef enum logic [1:0] {PAGE_DEF, PAGE_EXT, PAGE_EE} page_t;
    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
    } state_t;
endpackage

/* core/two_wire_slave_command_port.sv */
// two-wire slave command port: protocol engine, pointer, pages, reboot
`timescale 1ns/1ps
module two_wire_slave_command_port
    import twi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_select_input_i,
    input wire logic eeprom_busy_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [7:0] mem_addr_o,
    output page_t mem_page_o,
    output logic mem_wr_o,
    output logic [7:0] mem_wdata_o,
    output logic boot_copy_o,
    output logic [7:0] boot_addr_o,
    output logic fault_store_o
);
    bus_sense_if sense ();

    state_t state_reg;
    page_t page_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic [7:0] cmd_reg;
    logic [7:0] blk_left_reg;
    logic [7:0] boot_addr_reg;
    logic [7:0] wdata_reg;
    logic sda_oe_reg;
    logic rw_reg;
    logic ok_reg;
    logic mack_reg;
    logic blk_rd_reg;
    logic blk_wr_reg;
    logic cnt_phase_reg;
    logic cmd_pend_reg;
    logic count_tx_reg;
    logic boot_busy_reg;
    logic wr_reg;
    logic fault_reg;
    logic idle_pin_reg;
    logic start_pin_reg;
    logic low_pin_reg;
    logic [1:0] sel;
    logic busy;
    logic addr_hit;
    logic cmd_ok;
    logic data_ok;
    logic ack_now;
    logic rx_done;
    logic cmd_ack_ev;
    logic wr_ev;
    logic rd_ev;
    logic reboot_go;
    logic [7:0] tx_load;

    function automatic logic is_cmd(input logic [7:0] b);
        return (b >= CMD_BLK_WR) && (b <= CMD_EE_OFF);
    endfunction

    function automatic logic [7:0] page_last(input page_t p);
        case (p)
            PAGE_EXT: return EXT_LAST;
            PAGE_EE: return EE_LAST;
            default: return DEF_LAST;
        endcase
    endfunction

    // pointer sticks at the last location of the page
    function automatic logic [7:0] sat_inc(input logic [7:0] a,
                                           input page_t p);
        if (a >= page_last(p)) begin
            return a;
        end
        return a + 8'h01;
    endfunction

    // select pin: gnd, high, follows scl, follows sda
    function automatic logic [1:0] sel_decode(input logic idle,
                                              input logic strt,
                                              input logic low);
        if (!idle) begin
            return 2'h0;
        end else if (!strt) begin
            return 2'h3;
        end else if (!low) begin
            return 2'h2;
        end
        return 2'h1;
    endfunction

    bus_sense u_sense (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .asel_i(address_select_input_i),
        .bus(sense)
    );

    // decisions for the ninth clock of a received byte
    assign sel = sel_decode(idle_pin_reg, start_pin_reg, low_pin_reg); // RL10
    assign busy = boot_busy_reg | eeprom_busy_i;
    assign addr_hit = (shift_reg[7:4] == DEV_ID) && (shift_reg[3:2] == sel); // RL10
    assign cmd_ok = !busy && (is_cmd(shift_reg) ||
                    shift_reg <= page_last(page_reg)); // RL9 RL11 RL12 RL16 RL17
    assign data_ok = !busy && (cnt_phase_reg ?
                     (shift_reg != 8'h00 && shift_reg <= BLK_BYTES) :
                     blk_left_reg != 8'h00); // RL15 RL23
    assign rx_done = sense.scl_fall && bit_cnt_reg == BITS_PER_WORD &&
                     !sense.start && !sense.stop &&
                     (state_reg == ST_ADDR || state_reg == ST_CMD ||
                      state_reg == ST_DATA); // RL2
    assign cmd_ack_ev = rx_done && state_reg == ST_CMD && cmd_ok;
    assign wr_ev = rx_done && state_reg == ST_DATA && data_ok &&
                   !cnt_phase_reg;
    assign rd_ev = sense.scl_rise && state_reg == ST_TX_ACK &&
                   !count_tx_reg && !sense.stop;
    assign reboot_go = sense.stop && cmd_pend_reg && cmd_reg == CMD_REBOOT;
    assign tx_load = (state_reg == ST_ADDR_ACK && blk_rd_reg) ?
                     BLK_BYTES : mem_rdata_i; // RL24

    always_comb begin
        case (state_reg)
            ST_ADDR: ack_now = addr_hit;
            ST_CMD: ack_now = cmd_ok;
            ST_DATA: ack_now = data_ok;
            default: ack_now = 1'b0;
        endcase
    end

    // protocol engine; stop beats start beats bit activity
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
            rw_reg <= 1'b0;
            ok_reg <= 1'b0;
            mack_reg <= 1'b0;
            blk_rd_reg <= 1'b0;
            blk_wr_reg <= 1'b0;
            cnt_phase_reg <= 1'b0;
            blk_left_reg <= 8'h00;
            cmd_reg <= 8'h00;
            cmd_pend_reg <= 1'b0;
            count_tx_reg <= 1'b0;
        end else if (sense.stop) begin
            state_reg <= ST_IDLE; // RL5
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            blk_rd_reg <= 1'b0;
            blk_wr_reg <= 1'b0;
            cmd_pend_reg <= 1'b0;
        end else if (sense.start) begin
            // block-read intent survives a repeated start
            state_reg <= ST_ADDR; // RL4 RL6
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_CMD, ST_DATA: begin
                    if (sense.scl_rise && bit_cnt_reg != BITS_PER_WORD) begin
                        shift_reg <= {shift_reg[6:0], sense.sda};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1; // RL2
                    end else if (rx_done) begin
                        bit_cnt_reg <= 4'h0;
                        sda_oe_reg <= ack_now; // RL7 RL9
                        ok_reg <= ack_now;
                        if (state_reg == ST_ADDR) begin
                            rw_reg <= shift_reg[0];
                            state_reg <= addr_hit ? ST_ADDR_ACK : ST_IGNORE; // RL26
                        end else if (state_reg == ST_CMD) begin
                            state_reg <= ST_CMD_ACK;
                            if (cmd_ok) begin
                                cmd_reg <= shift_reg;
                                cmd_pend_reg <= is_cmd(shift_reg);
                                blk_wr_reg <= shift_reg == CMD_BLK_WR;
                                cnt_phase_reg <= shift_reg == CMD_BLK_WR; // RL23
                                blk_rd_reg <= shift_reg == CMD_BLK_RD;
                                blk_left_reg <= is_cmd(shift_reg) ?
                                                8'h00 : 8'h01;
                            end
                        end else begin
                            state_reg <= ST_DATA_ACK;
                            cmd_pend_reg <= 1'b0;
                            if (data_ok && cnt_phase_reg) begin
                                blk_left_reg <= shift_reg; // RL23
                                cnt_phase_reg <= 1'b0;
                            end else if (data_ok) begin
                                blk_left_reg <= blk_left_reg - 8'h01;
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (sense.scl_fall && rw_reg) begin
                        tx_reg <= tx_load; // RL14 RL24
                        count_tx_reg <= blk_rd_reg;
                        sda_oe_reg <= ~tx_load[7];
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_TX;
                    end else if (sense.scl_fall) begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= ST_CMD;
                    end
                end
                ST_CMD_ACK, ST_DATA_ACK: begin
                    if (sense.scl_fall) begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= ok_reg ? ST_DATA : ST_IGNORE;
                    end
                end
                ST_TX: begin
                    if (sense.scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (sense.scl_fall &&
                                 bit_cnt_reg == BITS_PER_WORD) begin
                        sda_oe_reg <= 1'b0; // RL8
                        state_reg <= ST_TX_ACK;
                    end else if (sense.scl_fall) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_oe_reg <= ~tx_reg[6]; // RL3
                    end
                end
                ST_TX_ACK: begin
                    if (sense.scl_rise) begin
                        mack_reg <= ~sense.sda; // RL8
                    end else if (sense.scl_fall && mack_reg) begin
                        tx_reg <= tx_load;
                        count_tx_reg <= 1'b0;
                        sda_oe_reg <= ~tx_load[7];
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_TX;
                    end else if (sense.scl_fall) begin
                        state_reg <= ST_IGNORE; // RL24
                    end
                end
                default: ;
            endcase
        end
    end

    // pointer and page; nack paths never reach the pointer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ptr_reg <= PTR_RESET;
            page_reg <= PAGE_DEF;
        end else if (reboot_go) begin
            ptr_reg <= PTR_RESET; // RL18
            page_reg <= PAGE_DEF;
        end else begin
            if (cmd_ack_ev && !is_cmd(shift_reg)) begin
                ptr_reg <= shift_reg; // RL11 RL13 RL16
            // step with the registered strobe so the byte lands first
            end else if ((wr_reg && blk_wr_reg) || rd_ev) begin
                ptr_reg <= sat_inc(ptr_reg, page_reg); // RL14 RL23
            end
            if (sense.stop && cmd_pend_reg) begin
                case (cmd_reg)
                    CMD_EXT_ON: page_reg <= PAGE_EXT; // RL20
                    CMD_EE_ON: page_reg <= PAGE_EE; // RL21
                    CMD_EXT_OFF, CMD_EE_OFF: page_reg <= PAGE_DEF; // RL20 RL21
                    default: ;
                endcase
            end
        end
    end

    // write strobe and fault-store request
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_reg <= 1'b0;
            wdata_reg <= 8'h00;
            fault_reg <= 1'b0;
        end else begin
            wr_reg <= wr_ev; // RL15 RL17
            if (wr_ev) begin
                wdata_reg <= shift_reg;
            end
            fault_reg <= sense.stop && cmd_pend_reg &&
                         cmd_reg == CMD_FAULT; // RL19
        end
    end

    // reboot copy walk, also run once after reset like power-on
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            boot_busy_reg <= 1'b1;
            boot_addr_reg <= BOOT_FIRST;
        end else if (reboot_go) begin
            boot_busy_reg <= 1'b1; // RL18
            boot_addr_reg <= BOOT_FIRST;
        end else if (boot_busy_reg) begin
            if (boot_addr_reg == BOOT_LAST) begin
                boot_busy_reg <= 1'b0;
            end else begin
                boot_addr_reg <= boot_addr_reg + 8'h01;
            end
        end
    end

    // select pin levels seen at idle, at start and at first scl low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idle_pin_reg <= 1'b1;
            start_pin_reg <= 1'b1;
            low_pin_reg <= 1'b1;
        end else begin
            if (state_reg == ST_IDLE && sense.scl && sense.sda) begin
                idle_pin_reg <= sense.asel;
            end
            if (sense.start) begin
                start_pin_reg <= sense.asel;
            end
            if (sense.scl_fall && state_reg == ST_ADDR &&
                bit_cnt_reg == 4'h0) begin
                low_pin_reg <= sense.asel; // RL10
            end
        end
    end

    // open drain: only ever pulls low, and scl is never driven
    assign sda_o = 1'b0; // RL1
    assign sda_oe_o = sda_oe_reg;
    assign mem_addr_o = ptr_reg;
    assign mem_page_o = page_reg;
    assign mem_wr_o = wr_reg;
    assign mem_wdata_o = wdata_reg;
    assign boot_copy_o = boot_busy_reg;
    assign boot_addr_o = boot_addr_reg;
    assign fault_store_o = fault_reg;

    sequence s_reboot_req;
        sense.stop && cmd_pend_reg && cmd_reg == CMD_REBOOT;
    endsequence
    sequence s_copy_walk;
        (boot_copy_o && boot_addr_o == BOOT_FIRST) ##110
        (boot_copy_o && boot_addr_o == BOOT_LAST) ##1 !boot_copy_o;
    endsequence
    sequence s_cmd_end;
        rx_done && state_reg == ST_CMD;
    endsequence

    property p_stop_idle;
        @(posedge clk_i) disable iff (!rst_n_i)
        sense.stop |=> state_reg == ST_IDLE && !sda_oe_o;
    endproperty
    a_stop_idle: assert property (p_stop_idle) // RL5
        else $error("stop did not return to idle");

    property p_start_addr;
        @(posedge clk_i) disable iff (!rst_n_i)
        sense.start && !sense.stop |=> state_reg == ST_ADDR &&
                                       bit_cnt_reg == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) // RL4
        else $error("start did not begin address reception");

    property p_rs_keep;
        @(posedge clk_i) disable iff (!rst_n_i)
        sense.start && !sense.stop && blk_rd_reg |=> blk_rd_reg;
    endproperty
    a_rs_keep: assert property (p_rs_keep) // RL6
        else $error("repeated start lost transaction state");

    property p_ack_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_ADDR_ACK) && !sense.scl_fall && !sense.stop &&
        !sense.start |=> sda_oe_o && !sda_o;
    endproperty
    a_ack_hold: assert property (p_ack_hold) // RL7
        else $error("address acknowledge not held low");

    property p_tx_release;
        @(posedge clk_i) disable iff (!rst_n_i)
        state_reg == ST_TX_ACK |-> !sda_oe_o;
    endproperty
    a_tx_release: assert property (p_tx_release) // RL8
        else $error("sda driven during master acknowledge");

    property p_busy_nack;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_cmd_end and busy |=> state_reg == ST_CMD_ACK && !sda_oe_o;
    endproperty
    a_busy_nack: assert property (p_busy_nack) // RL9
        else $error("byte acknowledged while busy");

    property p_ptr_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        sense.stop && state_reg == ST_CMD |=> $stable(ptr_reg);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) // RL13
        else $error("pointer moved on early stop");

    property p_reboot;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_reboot_req |=> s_copy_walk;
    endproperty
    a_reboot: assert property (p_reboot) // RL18
        else $error("reboot copy walk wrong");

    property p_page_ext;
        @(posedge clk_i) disable iff (!rst_n_i)
        sense.stop && cmd_pend_reg && cmd_reg == CMD_EXT_ON
        |=> mem_page_o == PAGE_EXT;
    endproperty
    a_page_ext: assert property (p_page_ext) // RL20
        else $error("extended page not selected");

    property p_quiet;
        @(posedge clk_i) disable iff (!rst_n_i)
        state_reg == ST_IGNORE || state_reg == ST_IDLE |-> !sda_oe_o;
    endproperty
    a_quiet: assert property (p_quiet) // RL26
        else $error("sda driven while not addressed");

    property p_sda_timing;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(sda_oe_o) |-> !sense.scl;
    endproperty
    a_sda_timing: assert property (p_sda_timing) // RL3
        else $error("sda pulled low while scl high");
endmodule

/* dv/twi_master_model.sv */
// bus master model: start, stop, byte write and byte read
`timescale 1ns/1ps
module twi_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // wait whole clocks, then step just past the edge
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // sda moves 500 ns into scl low, keeping the hold time
    task automatic bit_io(input logic b, output logic r);
        tk(5);
        sda_o = b;
        tk(10);
        scl_o = 1'b1;
        tk(8);
        r = sda_i;
        tk(7);
        scl_o = 1'b0;
    endtask
    task automatic start();
        tk(5);
        sda_o = 1'b1;
        tk(10);
        scl_o = 1'b1;
        tk(15);
        sda_o = 1'b0;
        tk(15);
        scl_o = 1'b0;
    endtask
    // separate scl pulse from the preceding start; a start that follows shares this high phase
    task automatic stop();
        tk(5);
        sda_o = 1'b0;
        tk(10);
        scl_o = 1'b1;
        tk(15);
        sda_o = 1'b1;
        tk(15);
    endtask
    // n below 8 leaves the word unfinished on purpose
    task automatic wr_byte(input logic [7:0] d, input int n,
                           output logic ack);
        logic r;
        for (int i = 0; i < n; i++) bit_io(d[7-i], r);
        ack = 1'b0;
        if (n == 8) begin
            bit_io(1'b1, r);
            ack = ~r;
        end
    endtask
    // released sda reads the pull-up level
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) bit_io(1'b1, d[7-i]);
        bit_io(nack, r);
    endtask
endmodule

/* dv/two_wire_slave_command_port_tb_top.sv */
// testbench for the two-wire slave command port
`timescale 1ns/1ps
module two_wire_slave_command_port_tb_top;
    import twi_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic busy = 1'b0;
    logic asel = 1'b0;
    logic scl, sda_m, sda, sdo, sda_oe, wr, boot, flt, a, k, j;
    logic [7:0] addr, wdata, wr_addr, wr_data, d, baddr, blast;
    page_t page;
    int failures = 0;
    int compares = 0;
    int flt_n = 0;
    int boot_n = 0;
    always #50 clk_i = ~clk_i;
    // open drain line with pull-up
    assign sda = sda_m & (~sda_oe | sdo);
    twi_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
        .sda_o(sda_m));
    two_wire_slave_command_port uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(sda_oe),
        .address_select_input_i(asel), .eeprom_busy_i(busy),
        .mem_rdata_i(addr ^ 8'h3c), .mem_addr_o(addr), .mem_page_o(page),
        .mem_wr_o(wr), .mem_wdata_o(wdata), .boot_copy_o(boot),
        .boot_addr_o(baddr), .fault_store_o(flt));
    // capture side effects at the memory port
    always @(posedge clk_i) begin
        if (wr === 1'b1) begin
            wr_addr <= addr;
            wr_data <= wdata;
        end
        if (boot === 1'b1) begin
            blast <= baddr;
        end
        flt_n <= flt_n + int'(flt === 1'b1);
        boot_n <= boot_n + int'(boot === 1'b1);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // send byte with stop; k holds the answer to the code
    task automatic snd(input logic [7:0] c);
        m.start();
        m.wr_byte(8'ha0, 8, a);
        m.wr_byte(c, 8, k);
        m.stop();
        m.tk(20);
    endtask
    task automatic t_write();
        m.start();
        m.wr_byte(8'ha0, 8, a);
        m.wr_byte(8'h20, 8, k);
        m.wr_byte(8'h5a, 8, j);
        m.stop();
        chk({5'h0, a, k, j}, 8'h07);
        chk(wr_addr, 8'h20);
        chk(wr_data, 8'h5a);
        chk(8'(page), 8'(PAGE_DEF));
        m.start();
        m.wr_byte(8'ha0, 8, a);
        m.wr_byte(8'h94, 8, k);
        m.wr_byte(8'h02, 8, k);
        m.wr_byte(8'h11, 8, k);
        m.wr_byte(8'h22, 8, j);
        m.stop();
        chk({7'h0, j}, 8'h01);
        chk(wr_addr, 8'h21);
        chk(wr_data, 8'h22);
        chk(addr, 8'h22);
    endtask
    // bad pointer and early stop leave the pointer alone, busy is nacked, select pin sets the address
    task automatic t_refuse();
        snd(8'h80);
        chk({7'h0, k}, 8'h00);
        chk(addr, 8'h22);
        m.start();
        m.wr_byte(8'ha0, 8, a);
        m.wr_byte(8'h40, 4, k);
        m.stop();
        chk(addr, 8'h22);
        busy = 1'b1;
        snd(8'h30);
        busy = 1'b0;
        chk({7'h0, k}, 8'h00);
        m.start();
        m.wr_byte(8'ha4, 8, a);
        m.stop();
        chk({7'h0, a}, 8'h00);
        asel = 1'b1;
        m.start();
        m.wr_byte(8'ha4, 8, a);
        m.stop();
        asel = 1'b0;
        chk({7'h0, a}, 8'h01);
    endtask
    // read byte, then receive byte steps on
    task automatic t_read();
        m.start();
        m.wr_byte(8'ha0, 8, a);
        m.wr_byte(8'h10, 8, k);
        for (int i = 0; i < 2; i++) begin
            m.start();
            m.wr_byte(8'ha1, 8, a);
            m.rd_byte(1'b1, d);
            chk(d, 8'(8'h10 + i) ^ 8'h3c);
        end
        m.stop();
        chk(addr, 8'h12);
        m.start();
        m.wr_byte(8'ha0, 8, a);
        m.wr_byte(8'h95, 8, k);
        m.start();
        m.wr_byte(8'ha1, 8, a);
        m.rd_byte(1'b0, d);
        chk(d, BLK_BYTES);
        m.rd_byte(1'b1, d);
        m.stop();
        chk(d, 8'h12 ^ 8'h3c);
        chk(addr, 8'h13);
    endtask
    task automatic t_cmds();
        logic [7:0] c[7] = '{8'h94, 8'h95, 8'h98, 8'h9a, 8'h9b, 8'h98, 8'h99};
        page_t p[7] = '{PAGE_DEF, PAGE_DEF, PAGE_EXT, PAGE_EE, PAGE_DEF,
            PAGE_EXT, PAGE_DEF};
        for (int i = 0; i < 7; i++) begin
            snd(c[i]);
            chk({7'h0, k}, 8'h01);
            chk(8'(page), 8'(p[i]));
        end
        snd(8'h97);
        chk(8'(flt_n), 8'h01);
        boot_n = 0;
        snd(8'h96);
        m.tk(150);
        chk(8'(boot_n), 8'h6f);
        chk(blast, 8'h7d);
        chk(addr, 8'h00);
    endtask
    // stop a hang well past the expected run length
    initial begin
        #8ms;
        failures++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        m.tk(130);
        flt_n = 0;
        t_write();
        t_refuse();
        t_read();
        t_cmds();
        finish_test();
    end
endmodule
